// >>> pkg/opw_consts.svh
// Purpose: Timing counts and pin conventions for the one-time-programmable memory writer.
// Assumes: 40 MHz system clock, period 25 ns.
// Notes:   Times are kept in their own units and turned into clock counts here.
`ifndef OPW_CONSTS_SVH
`define OPW_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define OPW_CLK_KHZ          40000

// ----------------------------------------------------------------------------
// Times in their printed units
// ----------------------------------------------------------------------------
`define OPW_SETUP_US         2
`define OPW_VPP_SETUP_MS     1
`define OPW_PULSE_US         1000
`define OPW_OVER_US          3000
`define OPW_ACCESS_NS        200

// ----------------------------------------------------------------------------
// Cycle counts derived from the times (least times rounded up)
// ----------------------------------------------------------------------------
`define OPW_SETUP_CYC        ((`OPW_SETUP_US * `OPW_CLK_KHZ + 999) / 1000)
`define OPW_VPP_SETUP_CYC    (`OPW_VPP_SETUP_MS * `OPW_CLK_KHZ)
`define OPW_PULSE_CYC        ((`OPW_PULSE_US * `OPW_CLK_KHZ + 999) / 1000)
`define OPW_OVER_CYC         ((`OPW_OVER_US * `OPW_CLK_KHZ + 999) / 1000)
`define OPW_ACCESS_CYC       ((`OPW_ACCESS_NS * `OPW_CLK_KHZ + 999999) / 1000000 + 1)

// ----------------------------------------------------------------------------
// Attempt limit and bus widths
// ----------------------------------------------------------------------------
`define OPW_MAX_TRIES        25
`define OPW_ADDR_W           15
`define OPW_DATA_W           8

`endif

// >>> pkg/opw_pkg.sv
// Purpose: Types shared by the memory writer.
// Assumes: Nothing beyond the constants header.
// Notes:   States carry no explicit codes.
package opw_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OPW_IDLE, OPW_VPP_WAIT, OPW_SETUP, OPW_PULSE, OPW_HOLD,
    OPW_VFY, OPW_OVER_SETUP, OPW_OVER, OPW_NEXT, OPW_RD_SETUP,
    OPW_RD, OPW_FAIL
  } opw_state_t;

endpackage : opw_pkg

// >>> src/opw_writer.sv
// Purpose: Host-side writer that programs and reads the one-time memory over its pins.
// Assumes: Pins are driven from flip-flops; the supply levels are switched outside
//          under HV_EN_N and VDD_PROG; the data pins reach us through three flops.
// Notes:   One command at a time; START_WR programs a block, START_RD reads one byte.
//
// Summary of operation
// - Hold reset low and raise programming voltage before any access.
// - Present start address first, then the data byte.
// - Each attempt drives program strobe low for one 1 ms pulse.
// - After each pulse read back with output-enable low; match goes on.
// - Count attempts per address; after 25 failures flag defective and stop.
// - After a match, over-program for 3 ms times attempts used.
// - Increment address and repeat until the final address is done.
// - For read-out, hold reset low, raise voltage, drive the wanted address.
// - Never drive both strobes low while programming voltages are applied; read-out drops PGM_N and OE_N together with HV_EN_N low.
`include "opw_consts.svh"

module opw_writer
  import opw_pkg::*;
#(
  parameter int ADDR_W    = `OPW_ADDR_W,
  parameter int DATA_W    = `OPW_DATA_W,
  parameter int MAX_TRIES = `OPW_MAX_TRIES,
  parameter int PULSE_CYC = `OPW_PULSE_CYC,
  parameter int OVER_CYC  = `OPW_OVER_CYC,
  parameter int VPP_CYC   = `OPW_VPP_SETUP_CYC
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              SRST,
  // User command side
  input  wire logic              START_WR,
  input  wire logic              START_RD,
  input  wire logic [ADDR_W-1:0] FIRST_ADDR,
  input  wire logic [ADDR_W-1:0] LAST_ADDR,
  input  wire logic [DATA_W-1:0] WR_DATA,
  output logic                   DATA_REQ,
  output logic [ADDR_W-1:0]      CUR_ADDR,
  output logic                   BUSY,
  output logic                   DONE,
  output logic                   DEFECT,
  output logic                   RD_VALID,
  output logic [DATA_W-1:0]      RD_DATA,
  // Device pins
  output logic                   DEV_RESET_N,
  output logic                   HV_EN_N,
  output logic                   VDD_PROG,
  output logic [ADDR_W-1:0]      PROM_ADDRESS,
  output logic                   PGM_N,
  output logic                   OE_N,
  input  wire logic [DATA_W-1:0] PROM_DATA_I,
  output logic [DATA_W-1:0]      PROM_DATA_O,
  output logic                   PROM_DATA_OE_N
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (MAX_TRIES < 1 || MAX_TRIES > 255 || PULSE_CYC < 1 || OVER_CYC < 1 ||
      VPP_CYC < 1 || ADDR_W < 1 || DATA_W < 1) begin : g_bad
    $error("opw_writer: parameter out of range");
  end

  localparam int CW = 32;
  localparam logic [CW-1:0] SETUP_N  = CW'(`OPW_SETUP_CYC);
  localparam logic [CW-1:0] ACCESS_N = CW'(`OPW_ACCESS_CYC);

  opw_state_t        st_q, st_d;
  logic [CW-1:0]     cnt_q;
  logic [7:0]        tries_q;
  logic [ADDR_W-1:0] addr_q, last_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] din1_q, din2_q, din3_q;
  logic              rd_mode_q;
  logic [ADDR_W-1:0] pa_q;
  logic              hv_n_q, vdd_q, pgm_n_q, oe_n_q, drive_n_q, busy_q;
  logic              dreq_q, done_q, def_q, rv_q;
  logic [DATA_W-1:0] rd_q;

  // --------------------------------------------------------------------------
  // Decode of the sequencer
  // --------------------------------------------------------------------------
  // Data is taken as seen once the second and third stages agree.
  wire               din_ok    = (din2_q == din3_q);
  wire               cnt_zero  = (cnt_q == '0);
  wire               match     = din_ok && (din3_q == data_q);
  wire               last_addr = (pa_q == last_q);
  wire               start_ok  = (st_q == OPW_IDLE) && (START_WR || START_RD);
  // Mode of the command being taken, so the supply pin is right from the first cycle.
  wire               rd_mode_d = start_ok ? !START_WR : rd_mode_q;
  wire               tries_out = (tries_q >= 8'(MAX_TRIES));
  // The over-program length grows with the attempts; the wide product cannot wrap.
  wire [CW-1:0]      over_len  = CW'(OVER_CYC) * CW'(tries_q);

  // Next state; the counter is reloaded on every state change.
  always_comb begin
    st_d = st_q;
    case (st_q)
      OPW_IDLE:       if (START_WR) st_d = OPW_VPP_WAIT;
                      else if (START_RD) st_d = OPW_VPP_WAIT;
      OPW_VPP_WAIT:   if (cnt_zero) st_d = rd_mode_q ? OPW_RD_SETUP : OPW_SETUP;
      OPW_SETUP:      if (cnt_zero) st_d = OPW_PULSE;
      OPW_PULSE:      if (cnt_zero) st_d = OPW_HOLD;
      OPW_HOLD:       if (cnt_zero) st_d = OPW_VFY;
      OPW_VFY:        if (cnt_zero) begin
                        if (match) st_d = OPW_OVER_SETUP;
                        else if (tries_out) st_d = OPW_FAIL;
                        else st_d = OPW_SETUP;
                      end
      OPW_OVER_SETUP: if (cnt_zero) st_d = OPW_OVER;
      OPW_OVER:       if (cnt_zero) st_d = OPW_NEXT;
      OPW_NEXT:       if (cnt_zero) st_d = last_addr ? OPW_IDLE : OPW_SETUP;
      OPW_RD_SETUP:   if (cnt_zero) st_d = OPW_RD;
      OPW_RD:         if (cnt_zero) st_d = OPW_IDLE;
      OPW_FAIL:       st_d = OPW_IDLE;
      default:        st_d = OPW_IDLE;
    endcase
  end

  // Counter load value for the state being entered.
  logic [CW-1:0] load_v;
  always_comb begin
    case (st_d)
      OPW_VPP_WAIT: load_v = CW'(VPP_CYC);
      OPW_PULSE:    load_v = CW'(PULSE_CYC) - 1;
      OPW_OVER:     load_v = over_len - 1;
      OPW_VFY:      load_v = ACCESS_N;
      OPW_RD:       load_v = ACCESS_N;
      default:      load_v = SETUP_N;
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencer registers
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q  <= OPW_IDLE;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= (st_d != st_q) ? load_v : (cnt_zero ? cnt_q : cnt_q - 1);
    end
  end

  // Three-stage sampling of the data pins, which the device drives.
  always_ff @(posedge CLK) begin
    din1_q <= PROM_DATA_I;
    din2_q <= din1_q;
    din3_q <= din2_q;
  end

  // Address, data, attempt count and result flags.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      addr_q    <= '0;
      pa_q      <= '0;
      last_q    <= '0;
      data_q    <= '0;
      tries_q   <= '0;
      rd_mode_q <= 1'b0;
      dreq_q    <= 1'b0;
      done_q    <= 1'b0;
      def_q     <= 1'b0;
      rv_q      <= 1'b0;
      rd_q      <= '0;
    end else begin
      dreq_q    <= 1'b0;
      done_q    <= 1'b0;
      rv_q      <= 1'b0;
      rd_mode_q <= rd_mode_d;
      if (start_ok) begin
        addr_q  <= FIRST_ADDR;
        pa_q    <= FIRST_ADDR;
        last_q  <= START_WR ? LAST_ADDR : FIRST_ADDR;
        tries_q <= '0;
        def_q   <= 1'b0;
      end
      // The user byte is latched as the first attempt's setup begins; a retry after verify keeps it.
      if (st_d == OPW_SETUP && st_q != OPW_SETUP) begin
        data_q <= (st_q == OPW_VFY) ? data_q : WR_DATA;
        dreq_q <= (st_q != OPW_VFY);
      end
      if (st_d == OPW_PULSE && st_q != OPW_PULSE) tries_q <= tries_q + 8'h01;
      // The user address moves on as the OPW_NEXT wait starts, so the next byte has
      // long settled at WR_DATA when it is latched; the address pins move later.
      if (st_d == OPW_NEXT && st_q != OPW_NEXT && !last_addr) begin
        addr_q <= addr_q + ADDR_W'(1);
      end
      if (st_q == OPW_NEXT && cnt_zero) begin
        pa_q    <= addr_q;
        tries_q <= '0;
        done_q  <= last_addr;
      end
      if (st_q == OPW_FAIL) begin
        def_q  <= 1'b1;
        done_q <= 1'b1;
      end
      if (st_q == OPW_RD && cnt_zero) begin
        if (din_ok) rd_q <= din3_q;
        rv_q   <= 1'b1;
        done_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  wire in_pgm  = (st_d == OPW_PULSE) || (st_d == OPW_OVER);
  wire in_vfy  = (st_d == OPW_VFY);
  wire in_rd   = (st_d == OPW_RD);
  wire active  = (st_d != OPW_IDLE) && (st_d != OPW_FAIL);

  // Strobes never overlap while writing; both fall together only in read.
  // The flops hold the pin levels themselves, so no gate sits between flop and pin.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      hv_n_q    <= 1'b1;
      vdd_q     <= 1'b0;
      pgm_n_q   <= 1'b1;
      oe_n_q    <= 1'b1;
      drive_n_q <= 1'b1;
      busy_q    <= 1'b0;
    end else begin
      hv_n_q    <= !active;
      vdd_q     <= active && !rd_mode_d;
      pgm_n_q   <= !(in_pgm || in_rd);
      oe_n_q    <= !(in_vfy || in_rd);
      drive_n_q <= !(active && !rd_mode_d && !in_vfy && !in_rd);
      busy_q    <= active;
    end
  end

  // The memory's own reset stays low for the whole session.
  assign DEV_RESET_N    = 1'b0;
  assign HV_EN_N        = hv_n_q;
  assign VDD_PROG       = vdd_q;
  assign PROM_ADDRESS   = pa_q;
  assign PGM_N          = pgm_n_q;
  assign OE_N           = oe_n_q;
  assign PROM_DATA_O    = data_q;
  assign PROM_DATA_OE_N = drive_n_q;
  assign DATA_REQ       = dreq_q;
  assign CUR_ADDR       = addr_q;
  assign BUSY           = busy_q;
  assign DONE           = done_q;
  assign DEFECT         = def_q;
  assign RD_VALID       = rv_q;
  assign RD_DATA        = rd_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_no_overlap: assert property (@(posedge CLK) disable iff (SRST)
    VDD_PROG |-> !(!PGM_N && !OE_N)) else $error("strobes overlap while writing");
  a_hv_first: assert property (@(posedge CLK) disable iff (SRST)
    (!PGM_N || !OE_N) |-> (!HV_EN_N && !DEV_RESET_N)) else $error("access without high voltage");
  a_pulse_len: assert property (@(posedge CLK) disable iff (SRST)
    $rose(st_q == OPW_PULSE) |-> (st_q == OPW_PULSE) [*8]) else $error("program pulse too short");
  a_vfy_after: assert property (@(posedge CLK) disable iff (SRST)
    $fell(st_q == OPW_PULSE) |-> ##[1:200] (st_q == OPW_VFY)) else $error("no verify after pulse");
  a_try_limit: assert property (@(posedge CLK) disable iff (SRST)
    tries_q <= 8'(MAX_TRIES)) else $error("attempt count beyond limit");
  a_fail_flag: assert property (@(posedge CLK) disable iff (SRST)
    (st_q == OPW_FAIL) |=> DEFECT) else $error("defect not flagged");
  a_over_len: assert property (@(posedge CLK) disable iff (SRST)
    $rose(st_q == OPW_OVER) |-> (cnt_q == over_len - 1)) else $error("over pulse length wrong");
  a_data_drive: assert property (@(posedge CLK) disable iff (SRST)
    !OE_N |-> PROM_DATA_OE_N) else $error("data driven during read back");
  c_write_ok:  cover property (@(posedge CLK) DONE && !DEFECT && !RD_VALID);
  c_defect:    cover property (@(posedge CLK) DEFECT);
  c_retry:     cover property (@(posedge CLK) (st_q == OPW_VFY) ##1 (st_q == OPW_SETUP));
  c_read:      cover property (@(posedge CLK) RD_VALID);

endmodule : opw_writer

// >>> dv/opw_prom_model.sv
// Purpose: Pin-level model of the one-time memory that the writer programs and reads.
// Assumes: VDD_PROG high means write supply; HV_EN_N low raises the mode pin.
// Notes:   A byte sticks only after STICK pulses; STICK of zero never sticks.
module opw_prom_model (
  // Mode and supply pins
  input  wire logic        DEV_RESET_N,
  input  wire logic        HV_EN_N,
  input  wire logic        VDD_PROG,
  // Address and strobes
  input  wire logic [14:0] PROM_ADDRESS,
  input  wire logic        PGM_N,
  input  wire logic        OE_N,
  // Data pins
  input  wire logic [7:0]  PROM_DATA_O,
  input  wire logic        PROM_DATA_OE_N,
  output logic [7:0]       DATA_OUT,
  // Bench controls
  input  wire logic [7:0]  STICK,
  output logic             FAULT
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem   [0:32767];
  logic [7:0] tries [0:32767];
  logic       vf_drv;
  logic       rd_drv;

  // Verify drives with only output enable low; read-out needs both strobes low.
  assign vf_drv = VDD_PROG && !OE_N && PGM_N;
  assign rd_drv = !VDD_PROG && !OE_N && !PGM_N;
  // Released lines show the inverse, since nothing pulls them to a level.
  assign #150 DATA_OUT = (vf_drv || rd_drv) ? mem[PROM_ADDRESS] : ~mem[PROM_ADDRESS];

  initial begin
    FAULT = 1'b0;
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'hFF;
      tries[i] = 8'h00;
    end
  end

  // Programming lands at the end of a pulse; cells can only be cleared, never set.
  always @(posedge PGM_N) begin
    if (VDD_PROG && !HV_EN_N && OE_N && !PROM_DATA_OE_N) begin
      tries[PROM_ADDRESS] = tries[PROM_ADDRESS] + 8'h01;
      if (STICK != 8'h00 && tries[PROM_ADDRESS] >= STICK) begin
        mem[PROM_ADDRESS] = mem[PROM_ADDRESS] & PROM_DATA_O;
      end
    end
  end

  // A strobe outside programming mode, or both strobes low under write supply, is a fault.
  always @(negedge PGM_N or negedge OE_N) begin
    if (DEV_RESET_N || HV_EN_N || (VDD_PROG && !PGM_N && !OE_N)) begin
      FAULT = 1'b1;
    end
  end
endmodule : opw_prom_model

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the memory writer against the pin-level model.
// Assumes: Shortened pulse counts; the model holds the memory contents.
// Notes:   Expected pulse widths and contents are rebuilt here from the algorithm.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PULSE = 10;
  localparam int OVER  = 30;
  logic        CLK, SRST, START_WR, START_RD, DATA_REQ, BUSY, DONE, DEFECT, RD_VALID;
  logic        DEV_RESET_N, HV_EN_N, VDD_PROG, PGM_N, OE_N, PROM_DATA_OE_N, fault;
  logic [14:0] FIRST_ADDR, LAST_ADDR, CUR_ADDR, PROM_ADDRESS;
  logic [7:0]  WR_DATA, RD_DATA, PROM_DATA_O, dev_out, stick;
  logic [7:0]  wr_tab  [0:32767];
  logic [7:0]  exp_mem [0:32767];
  logic [14:0] rd_list [9] = '{15'h0010, 15'h0011, 15'h0012, 15'h0013, 15'h7FFE,
                                15'h7FFF, 15'h0100, 15'h0101, 15'h0000};
  int          fails, cmp_count, width, seed, dreq_n;
  int          got_w[$], exp_w[$];
  wire  [7:0]  PROM_DATA_I = PROM_DATA_OE_N ? dev_out : PROM_DATA_O;

  opw_writer #(.PULSE_CYC(PULSE), .OVER_CYC(OVER), .VPP_CYC(5)) i_dut (.CLK, .SRST,
    .START_WR, .START_RD, .FIRST_ADDR, .LAST_ADDR, .WR_DATA, .DATA_REQ, .CUR_ADDR, .BUSY,
    .DONE, .DEFECT, .RD_VALID, .RD_DATA, .DEV_RESET_N, .HV_EN_N, .VDD_PROG, .PROM_ADDRESS,
    .PGM_N, .OE_N, .PROM_DATA_I, .PROM_DATA_O, .PROM_DATA_OE_N);
  opw_prom_model i_prom (.DEV_RESET_N, .HV_EN_N, .VDD_PROG, .PROM_ADDRESS, .PGM_N, .OE_N,
    .PROM_DATA_O, .PROM_DATA_OE_N, .DATA_OUT(dev_out), .STICK(stick), .FAULT(fault));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Data follows the address under work, as the writer expects while busy.
  always @(posedge CLK) WR_DATA <= wr_tab[CUR_ADDR];

  // Byte requests seen during the current write command.
  always @(posedge CLK) if (DATA_REQ === 1'b1) dreq_n <= dreq_n + 1;

  // Width of each write-supply pulse on the program strobe, in clock cycles.
  always @(posedge CLK) begin
    if (!PGM_N && VDD_PROG) begin
      width <= width + 1;
    end else if (width != 0) begin
      got_w.push_back(width);
      width <= 0;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  // Sampling on the falling edge keeps clear of the launching edge's updates.
  task automatic wait_done();
    int n;
    n = 0;
    while (DONE !== 1'b1 && n < 20000) begin
      @(negedge CLK);
      n++;
    end
    check(DONE, 1'b1, "done");
  endtask : wait_done

  task automatic run_wr(input logic [14:0] a0, input logic [14:0] a1, input logic [7:0] k);
    int          n_req;
    logic [14:0] a_end;
    n_req = 0;
    a_end = a0;
    dreq_n = 0;
    exp_w.delete();
    got_w.delete();
    for (int a = a0; a <= a1; a++) begin
      // An erased-looking byte would verify at once and hide the retries.
      if (wr_tab[a] == 8'hFF) wr_tab[a] = 8'hFE;
      n_req++;
      a_end = 15'(a);
      repeat ((k == 0) ? 25 : k) exp_w.push_back(PULSE);
      if (k == 0) break;
      exp_w.push_back(OVER * k);
      exp_mem[a] = exp_mem[a] & wr_tab[a];
    end
    @(posedge CLK);
    stick <= k;
    FIRST_ADDR <= a0;
    LAST_ADDR <= a1;
    START_WR <= 1'b1;
    @(posedge CLK);
    START_WR <= 1'b0;
    START_RD <= 1'b1;
    @(posedge CLK);
    START_RD <= 1'b0;
    wait_done();
    check(RD_VALID, 1'b0, "refused read");
    check(DEFECT, k == 8'h00, "defect");
    check(BUSY, 1'b0, "busy after done");
    check(CUR_ADDR, a_end, "final address");
    check(dreq_n, n_req, "byte requests");
    check(got_w.size(), exp_w.size(), "pulse count");
    foreach (exp_w[i]) check(got_w[i], exp_w[i], "pulse width");
    $display("test write block from %0h done", a0);
  endtask : run_wr

  task automatic run_rd(input logic [14:0] a);
    @(posedge CLK);
    FIRST_ADDR <= a;
    START_RD <= 1'b1;
    @(posedge CLK);
    START_RD <= 1'b0;
    wait_done();
    check(RD_VALID, 1'b1, "read valid");
    check(RD_DATA, exp_mem[a], "read data");
  endtask : run_rd

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // The defect block dominates the run; this span leaves it ample room.
  initial begin
    #(25 * 60000);
    fails++;
    $display("Error at %0t: run timed out", $time);
    conclude();
  end

  initial begin
    seed = 32'h5575BB4C;
    SRST = 1'b1;
    START_WR = 1'b0;
    START_RD = 1'b0;
    FIRST_ADDR = 15'h0000;
    LAST_ADDR = 15'h0000;
    WR_DATA = 8'h00;
    stick = 8'h01;
    width = 0;
    dreq_n = 0;
    for (int i = 0; i < 32768; i++) begin
      wr_tab[i] = 8'($random(seed));
      exp_mem[i] = 8'hFF;
    end
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    run_wr(15'h0010, 15'h0013, 8'h01);
    run_wr(15'h7FFE, 15'h7FFF, 8'h03);
    run_wr(15'h0100, 15'h0101, 8'h00);
    foreach (rd_list[i]) run_rd(rd_list[i]);
    $display("test read-out done");
    check(fault, 1'b0, "pin protocol");
    conclude();
  end
endmodule : tb_top
